/* common/sysctl_pkg.sv */
package sysctl_pkg;

  // register widths
  localparam int DATA_W = 64;
  localparam int HALF_W = 32;
  localparam int PHYS_ADDR_BITS = 52;

  // register selects carried by a control-register move
  typedef enum logic [2:0] {
    SEL_CTRL0,
    SEL_FAULT_ADDR,
    SEL_TABLE_BASE,
    SEL_FEATURE,
    SEL_TASK_PRI,
    SEL_FLAGS,
    SEL_EXT_FEATURE
  } regSel_type;

  // ctrl_reg_zero field positions
  localparam int PROT_MODE_BIT = 0;
  localparam int WAIT_MON_BIT = 1;
  localparam int FPU_TRAP_BIT = 2;
  localparam int TASK_SW_BIT = 3;
  localparam int COPROC_BIT = 4;
  localparam int NUM_ERR_BIT = 5;
  localparam int SUP_WP_BIT = 16;
  localparam int ALIGN_MASK_BIT = 18;
  localparam int WRITETHRU_BIT = 29;
  localparam int CACHE_DIS_BIT = 30;
  localparam int PAGING_BIT = 31;

  // proc_flags_reg alignment-check flag position
  localparam int FLAGS_AC_BIT = 18;

  // privilege level at which alignment checks apply
  localparam logic [1:0] USER_PRIV = 2'h3;

  // reset values
  localparam logic [63:0] CTRL0_RESET = 64'h0000_0000_0000_0010;
  localparam logic [63:0] ZERO_RESET = 64'h0;

  // fault vector codes
  localparam logic [7:0] VEC_INVALID_OP = 8'h06;
  localparam logic [7:0] VEC_DEV_UNAVAIL = 8'h07;
  localparam logic [7:0] VEC_GEN_PROT = 8'h0d;
  localparam logic [7:0] VEC_ALIGN = 8'h11;

endpackage

/* rtl/system_control_register_bank.sv */
// Contract
// - in 64-bit mode moves transfer all 64 bits, size prefixes ignored
// - other modes: write loads low 32, clears high 32; read returns low 32
// - 64-bit mode: nonzero high half of ctrl0 or feature raises protection fault
// - fault address register fully writable, no virtual-range check
// - table base writable except unimplemented physical address bits
// - flags high 32 bits read zero, nonzero loads ignored
// - extended feature register 64 bits in all modes
// - protected-mode bit turns protected mode and segment protection on/off
// - wait instruction faults device-unavailable only when monitor and task flags set
// - trap-all: fp faults unavailable, media invalid-opcode, save/restore unavailable
// - task flag set: fp or media instruction raises device-unavailable
// - task switch sets task flag; clear instruction or ctrl0 write clears
// - coprocessor type bit read-only, always one
// - numeric bit clear: ignore pin decides ignore or drive error output
// - numeric bit set: internal reporting, external pin path disabled
// - supervisor write-protect bit blocks supervisor writes to read-only pages
// - alignment fault needs mask bit, flags check and privilege three
// - writethrough bit stored and read back, no effect
// - cache disable: no allocation, read hits served, write hits evict
// - cache disable with paging ignores page cache-control bits
// - paging bit enables translation; setting with protection off faults
`timescale 1ns/1ps

module system_control_register_bank
  import sysctl_pkg::*;
#(
  parameter int PHYS_BITS = PHYS_ADDR_BITS
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control-register move from the pipeline
  input wire logic crReq,
  input wire logic crWrite,
  input wire logic [2:0] crSel,
  input wire logic [63:0] crWdata,
  input wire logic longMode64,
  output logic crDone_r,
  output logic [63:0] crRdata_r,
  output logic faultReq_r,
  output logic [7:0] faultVec_r,
  // task switching
  input wire logic taskSwitch,
  input wire logic clearTaskFlag,
  // instruction issue checks
  input wire logic instrValid,
  input wire logic instrIsFp,
  input wire logic instrIsMedia,
  input wire logic instrIsFpWait,
  input wire logic instrIsFpSaveRestore,
  output logic instrFault_r,
  output logic [7:0] instrFaultVec_r,
  // memory operand alignment
  input wire logic memValid,
  input wire logic memUnaligned,
  input wire logic [1:0] currentPrivLevel,
  output logic alignFault_r,
  // page fault address capture
  input wire logic pageFaultValid,
  input wire logic [63:0] pageFaultAddr,
  // floating-point error reporting
  input wire logic fpException,
  input wire logic fpErrorAck,
  input wire logic fpErrorIgnoreIn,
  output logic fpErrorOut_r,
  output logic fpInternalReport_r,
  // mode and cache controls, table base register
  output logic protModeOn_r,
  output logic pagingOn_r,
  output logic supWriteProtect_r,
  output logic cacheAllocEnable_r,
  output logic writeHitEvict_r,
  output logic ignorePageCacheBits_r,
  output logic [63:0] tableBase_r
);

  logic [63:0] ctrl0_r;
  logic [63:0] faultAddr_r;
  logic [63:0] feature_r;
  logic [63:0] taskPri_r;
  logic [63:0] extFeature_r;
  logic [31:0] flags_r;
  logic ignoreMeta_r;
  logic ignoreSync_r;
  logic [63:0] wval;
  logic wrBad;
  logic wrOk;
  logic [7:0] instrVec;
  logic instrHit;
  logic [63:0] ctrl0_nxt;
  regSel_type sel;
  logic [63:0] physMask;

  assign sel = regSel_type'(crSel);
  assign physMask = (PHYS_BITS >= DATA_W) ? {DATA_W{1'b1}}
                  : ((64'h1 << PHYS_BITS) - 64'h1);

  // low half only outside 64-bit mode
  function automatic logic [63:0] modeFit(input logic [63:0] v, input logic m64);
    modeFit = m64 ? v : {{HALF_W{1'b0}}, v[HALF_W-1:0]};
  endfunction

  // write value after mode sizing; the extended register is always full width
  always_comb
  begin
    if (sel == SEL_EXT_FEATURE)
      wval = crWdata;
    else
      wval = modeFit(crWdata, longMode64);
  end

  // write checks: reserved high halves and paging without protection
  always_comb
  begin
    wrBad = 1'b0;
    if (crReq && crWrite)
    begin
      unique case (sel)
        SEL_CTRL0:
          wrBad = (longMode64 && (|crWdata[63:HALF_W]))
               || (wval[PAGING_BIT] && !wval[PROT_MODE_BIT]);
        SEL_FEATURE:
          wrBad = longMode64 && (|crWdata[63:HALF_W]);
        default:
          wrBad = 1'b0;
      endcase
    end
  end

  assign wrOk = crReq && crWrite && !wrBad;

  // ctrl0 next value: set of the task flag wins over any clear
  always_comb
  begin
    ctrl0_nxt = ctrl0_r;
    if (wrOk && sel == SEL_CTRL0)
      ctrl0_nxt = wval;
    if (clearTaskFlag)
      ctrl0_nxt[TASK_SW_BIT] = 1'b0;
    if (taskSwitch)
      ctrl0_nxt[TASK_SW_BIT] = 1'b1;
    ctrl0_nxt[COPROC_BIT] = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ctrl0_r <= CTRL0_RESET;
    else
      ctrl0_r <= ctrl0_nxt;
  end

  // remaining registers; a page fault capture yields to a software write
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      faultAddr_r <= ZERO_RESET;
      tableBase_r <= ZERO_RESET;
      feature_r <= ZERO_RESET;
      taskPri_r <= ZERO_RESET;
      extFeature_r <= ZERO_RESET;
      flags_r <= '0;
    end
    else
    begin
      if (pageFaultValid)
        faultAddr_r <= pageFaultAddr;
      if (wrOk)
      begin
        unique case (sel)
          SEL_FAULT_ADDR: faultAddr_r <= wval;
          SEL_TABLE_BASE: tableBase_r <= wval & physMask;
          SEL_FEATURE: feature_r <= wval;
          SEL_TASK_PRI: taskPri_r <= wval;
          SEL_FLAGS: flags_r <= wval[HALF_W-1:0];
          SEL_EXT_FEATURE: extFeature_r <= wval;
          default: ;
        endcase
      end
    end
  end

  // move answer one cycle after the request
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      crDone_r <= 1'b0;
      crRdata_r <= ZERO_RESET;
      faultReq_r <= 1'b0;
      faultVec_r <= 8'h00;
    end
    else
    begin
      crDone_r <= crReq;
      faultReq_r <= wrBad || (crReq && crSel > 3'(SEL_EXT_FEATURE));
      faultVec_r <= wrBad ? VEC_GEN_PROT : VEC_INVALID_OP;
      if (crReq && !crWrite)
      begin
        unique case (sel)
          SEL_CTRL0: crRdata_r <= modeFit(ctrl0_r, longMode64);
          SEL_FAULT_ADDR: crRdata_r <= modeFit(faultAddr_r, longMode64);
          SEL_TABLE_BASE: crRdata_r <= modeFit(tableBase_r, longMode64);
          SEL_FEATURE: crRdata_r <= modeFit(feature_r, longMode64);
          SEL_TASK_PRI: crRdata_r <= modeFit(taskPri_r, longMode64);
          SEL_FLAGS: crRdata_r <= {{HALF_W{1'b0}}, flags_r};
          SEL_EXT_FEATURE: crRdata_r <= extFeature_r;
          default: crRdata_r <= ZERO_RESET;
        endcase
      end
    end
  end

  // instruction checks; trap-all is examined before the task flag
  always_comb
  begin
    instrHit = 1'b0;
    instrVec = VEC_DEV_UNAVAIL;
    if (instrIsFpWait)
      instrHit = ctrl0_r[WAIT_MON_BIT] && ctrl0_r[TASK_SW_BIT];
    else if (ctrl0_r[FPU_TRAP_BIT] && (instrIsFp || instrIsMedia))
    begin
      instrHit = 1'b1;
      if (instrIsMedia && !instrIsFpSaveRestore)
        instrVec = VEC_INVALID_OP;
    end
    else if (ctrl0_r[TASK_SW_BIT] && (instrIsFp || instrIsMedia))
      instrHit = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      instrFault_r <= 1'b0;
      instrFaultVec_r <= 8'h00;
    end
    else
    begin
      instrFault_r <= instrValid && instrHit;
      instrFaultVec_r <= instrVec;
    end
  end

  // alignment check needs all three conditions
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      alignFault_r <= 1'b0;
    else
      alignFault_r <= memValid && memUnaligned && ctrl0_r[ALIGN_MASK_BIT]
                   && flags_r[FLAGS_AC_BIT] && currentPrivLevel == USER_PRIV;
  end

  // ignore pin arrives asynchronously
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ignoreMeta_r <= 1'b0;
      ignoreSync_r <= 1'b0;
    end
    else
    begin
      ignoreMeta_r <= fpErrorIgnoreIn;
      ignoreSync_r <= ignoreMeta_r;
    end
  end

  // error output holds until acknowledged or numeric bit set; a new error beats the ack
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      fpErrorOut_r <= 1'b0;
      fpInternalReport_r <= 1'b0;
    end
    else
    begin
      fpInternalReport_r <= fpException && ctrl0_r[NUM_ERR_BIT];
      if (fpException && !ctrl0_r[NUM_ERR_BIT] && !ignoreSync_r)
        fpErrorOut_r <= 1'b1;
      else if (fpErrorAck || ctrl0_r[NUM_ERR_BIT])
        fpErrorOut_r <= 1'b0;
    end
  end

  // mode and cache controls lag ctrl0 by one cycle to stay registered
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      protModeOn_r <= 1'b0;
      pagingOn_r <= 1'b0;
      supWriteProtect_r <= 1'b0;
      cacheAllocEnable_r <= 1'b1;
      writeHitEvict_r <= 1'b0;
      ignorePageCacheBits_r <= 1'b0;
    end
    else
    begin
      protModeOn_r <= ctrl0_r[PROT_MODE_BIT];
      pagingOn_r <= ctrl0_r[PAGING_BIT];
      supWriteProtect_r <= ctrl0_r[SUP_WP_BIT];
      cacheAllocEnable_r <= !ctrl0_r[CACHE_DIS_BIT];
      writeHitEvict_r <= ctrl0_r[CACHE_DIS_BIT];
      ignorePageCacheBits_r <= ctrl0_r[CACHE_DIS_BIT] && ctrl0_r[PAGING_BIT];
    end
  end

  chk_ctrl0_upper_gp: assert property (@(posedge clk_sys) disable iff (reset)
    crReq && crWrite && sel == SEL_CTRL0 && longMode64 && (|crWdata[63:HALF_W])
    |=> faultReq_r && faultVec_r == VEC_GEN_PROT)
    else $error("high half write did not fault");

  chk_bad_write_kept: assert property (@(posedge clk_sys) disable iff (reset)
    wrBad && sel == SEL_FEATURE |=> feature_r == $past(feature_r))
    else $error("rejected write changed register");

  chk_legacy_high_clear: assert property (@(posedge clk_sys) disable iff (reset)
    crReq && crWrite && sel == SEL_FAULT_ADDR && !longMode64 && !pageFaultValid
    |=> faultAddr_r[63:HALF_W] == '0)
    else $error("legacy write left high half");

  chk_full_fault_addr: assert property (@(posedge clk_sys) disable iff (reset)
    crReq && crWrite && sel == SEL_FAULT_ADDR && longMode64
    |=> faultAddr_r == $past(crWdata))
    else $error("fault address not fully written");

  chk_flags_read_zero: assert property (@(posedge clk_sys) disable iff (reset)
    crReq && !crWrite && sel == SEL_FLAGS |=> crRdata_r[63:HALF_W] == '0 && crDone_r)
    else $error("flags high half not zero");

  chk_coproc_one: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 ctrl0_r[COPROC_BIT])
    else $error("coprocessor type bit cleared");

  chk_paging_gp: assert property (@(posedge clk_sys) disable iff (reset)
    crReq && crWrite && sel == SEL_CTRL0 && wval[PAGING_BIT] && !wval[PROT_MODE_BIT]
    |=> faultReq_r && faultVec_r == VEC_GEN_PROT)
    else $error("paging without protection did not fault");

  chk_wait_fault: assert property (@(posedge clk_sys) disable iff (reset)
    instrValid && instrIsFpWait
    |=> instrFault_r == $past(ctrl0_r[WAIT_MON_BIT] && ctrl0_r[TASK_SW_BIT]))
    else $error("wait instruction fault wrong");

  chk_task_set: assert property (@(posedge clk_sys) disable iff (reset)
    taskSwitch |=> ctrl0_r[TASK_SW_BIT])
    else $error("task switch did not set flag");

  chk_align_fault: assert property (@(posedge clk_sys) disable iff (reset)
    memValid && memUnaligned && currentPrivLevel != USER_PRIV |=> !alignFault_r)
    else $error("alignment fault outside user level");

  chk_fp_error_pin: assert property (@(posedge clk_sys) disable iff (reset)
    fpException && !ctrl0_r[NUM_ERR_BIT] && !ignoreSync_r |=> fpErrorOut_r)
    else $error("error output not driven");

  chk_cache_policy: assert property (@(posedge clk_sys) disable iff (reset)
    ctrl0_r[CACHE_DIS_BIT] |=> !cacheAllocEnable_r && writeHitEvict_r)
    else $error("cache disable not applied");

endmodule

/* tb/pipe_model.sv */
`timescale 1ns/1ps

module pipe_model
  import sysctl_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // control-register moves
  output logic crReq,
  output logic crWrite,
  output logic [2:0] crSel,
  output logic [63:0] crWdata,
  output logic longMode64,
  // task flag events
  output logic taskSwitch,
  output logic clearTaskFlag,
  // issue: fp, media, wait, save/restore
  output logic instrValid,
  output logic [3:0] instrKind
);
  // idle at time zero
  initial
  begin
    crReq = 1'b0;
    crWrite = 1'b0;
    crSel = 3'h0;
    crWdata = 64'h0;
    longMode64 = 1'b1;
    taskSwitch = 1'b0;
    clearTaskFlag = 1'b0;
    instrValid = 1'b0;
    instrKind = 4'h0;
  end

  // one-cycle move; released data inverted so stale values never match
  task automatic move(input logic wr, input logic [2:0] sel, input logic [63:0] d,
                      input logic m);
    @(negedge clk_sys);
    crReq = 1'b1;
    crWrite = wr;
    crSel = sel;
    crWdata = d;
    longMode64 = m;
    @(negedge clk_sys);
    crReq = 1'b0;
    crWdata = ~d;
  endtask

  // one instruction issue
  task automatic issue(input logic [3:0] k);
    @(negedge clk_sys);
    instrValid = 1'b1;
    instrKind = k;
    @(negedge clk_sys);
    instrValid = 1'b0;
    instrKind = ~k;
  endtask

  // hardware task switch or clear-flag instruction
  task automatic flag(input logic sw);
    @(negedge clk_sys);
    taskSwitch = sw;
    clearTaskFlag = ~sw;
    @(negedge clk_sys);
    taskSwitch = 1'b0;
    clearTaskFlag = 1'b0;
  endtask
endmodule

/* tb/system_control_register_bank_tb_top.sv */
`timescale 1ns/1ps

module system_control_register_bank_tb_top;
  import sysctl_pkg::*;

  localparam int PB = 40;
  localparam logic [63:0] PMASK = (64'h1 << PB) - 64'h1;

  // stimulus
  logic clk_sys, reset, crReq, crWrite, longMode64, taskSwitch, clearTaskFlag, instrValid;
  logic [2:0] crSel;
  logic [63:0] crWdata;
  logic [3:0] instrKind;
  logic memValid, memUnaligned, fpException, fpErrorAck, fpErrorIgnoreIn;
  logic [1:0] currentPrivLevel;
  logic pageFaultValid = 1'b0;
  logic [63:0] pageFaultAddr = 64'h0;
  wire instrIsFp = instrKind[3];
  wire instrIsMedia = instrKind[2];
  wire instrIsFpWait = instrKind[1];
  wire instrIsFpSaveRestore = instrKind[0];
  // answers
  logic crDone_r, faultReq_r, instrFault_r, alignFault_r, fpErrorOut_r, fpInternalReport_r;
  logic [63:0] crRdata_r, tableBase_r;
  logic [7:0] faultVec_r, instrFaultVec_r;
  logic protModeOn_r, pagingOn_r, supWriteProtect_r, cacheAllocEnable_r;
  logic writeHitEvict_r, ignorePageCacheBits_r;
  int failures = 0;
  int n_tests = 0;
  // expected ctrl0 contents, kept from the rules as the bench changes it
  logic [63:0] ctrlShadow;

  system_control_register_bank #(.PHYS_BITS(PB)) uut (.*);
  pipe_model pm (.*);

  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // move with answer judged in the cycle it stands; vec 0 means no fault
  task automatic mv(input logic wr, input logic [2:0] sel, input logic [63:0] d,
                    input logic m, input logic [7:0] vec);
    pm.move(wr, sel, d, m);
    chkBit(crDone_r, 1'b1);
    chkBit(faultReq_r, vec != 8'h0);
    if (vec != 8'h0)
      chk64(64'(faultVec_r), 64'(vec));
  endtask

  task automatic rd(input logic [2:0] sel, input logic m, input logic [63:0] exp);
    mv(1'b0, sel, 64'h0, m, 8'h0);
    chk64(crRdata_r, exp);
  endtask

  // read-modify-write keeps reserved positions as last read
  task automatic setCtrl(input logic [63:0] clr, input logic [63:0] set);
    rd(SEL_CTRL0, 1'b1, ctrlShadow);
    ctrlShadow = (ctrlShadow & ~clr) | set;
    mv(1'b1, SEL_CTRL0, ctrlShadow, 1'b1, 8'h0);
  endtask

  task automatic t_regs;
    rd(SEL_CTRL0, 1'b1, CTRL0_RESET);
    mv(1'b1, SEL_FAULT_ADDR, 64'hfedc_ba98_7654_3210, 1'b1, 8'h0);
    rd(SEL_FAULT_ADDR, 1'b1, 64'hfedc_ba98_7654_3210);
    rd(SEL_FAULT_ADDR, 1'b0, 64'h7654_3210);
    mv(1'b1, SEL_FAULT_ADDR, 64'hfedc_ba98_7654_3210, 1'b0, 8'h0);
    rd(SEL_FAULT_ADDR, 1'b1, 64'h7654_3210);
    mv(1'b1, SEL_EXT_FEATURE, 64'h8000_0000_0000_0501, 1'b0, 8'h0);
    rd(SEL_EXT_FEATURE, 1'b0, 64'h8000_0000_0000_0501);
    mv(1'b1, SEL_FLAGS, 64'h1_0000_0002, 1'b1, 8'h0);
    rd(SEL_FLAGS, 1'b1, 64'h2);
    mv(1'b1, SEL_TABLE_BASE, '1, 1'b1, 8'h0);
    rd(SEL_TABLE_BASE, 1'b1, PMASK);
    chk64(tableBase_r, PMASK);
    mv(1'b0, 3'h7, 64'h0, 1'b1, VEC_INVALID_OP);
    $display("test registers done");
  endtask

  // fault address capture, then a same-cycle move that must win over it
  task automatic t_pfault;
    @(negedge clk_sys);
    pageFaultValid = 1'b1;
    pageFaultAddr = 64'h8000_7fff_dead_b000;
    @(negedge clk_sys);
    pageFaultValid = 1'b0;
    rd(SEL_FAULT_ADDR, 1'b1, 64'h8000_7fff_dead_b000);
    fork
      mv(1'b1, SEL_FAULT_ADDR, 64'h0123_4567_89ab_cdef, 1'b1, 8'h0);
      begin
        @(negedge clk_sys);
        pageFaultValid = 1'b1;
        @(negedge clk_sys);
        pageFaultValid = 1'b0;
      end
    join
    rd(SEL_FAULT_ADDR, 1'b1, 64'h0123_4567_89ab_cdef);
    $display("test fault capture done");
  endtask

  task automatic t_faults;
    mv(1'b1, SEL_CTRL0, 64'h1_0000_0001, 1'b1, VEC_GEN_PROT);
    rd(SEL_CTRL0, 1'b1, 64'h10);
    mv(1'b1, SEL_FEATURE, 64'h8000_0000_0000_0000, 1'b1, VEC_GEN_PROT);
    mv(1'b1, SEL_CTRL0, 64'h8000_0000, 1'b1, VEC_GEN_PROT);
    mv(1'b1, SEL_CTRL0, 64'h2000_0000, 1'b1, 8'h0);
    rd(SEL_CTRL0, 1'b1, 64'h2000_0010);
    mv(1'b1, SEL_CTRL0, 64'h1_0000_0001, 1'b0, 8'h0);
    rd(SEL_CTRL0, 1'b1, 64'h11);
    ctrlShadow = 64'h11;
    $display("test faults done");
  endtask

  // control outputs trail the register by one cycle
  task automatic t_ctrl;
    setCtrl(64'h0, 64'hc001_0001);
    @(negedge clk_sys);
    chkBit(protModeOn_r, 1'b1);
    chkBit(pagingOn_r, 1'b1);
    chkBit(supWriteProtect_r, 1'b1);
    chkBit(cacheAllocEnable_r, 1'b0);
    chkBit(writeHitEvict_r, 1'b1);
    chkBit(ignorePageCacheBits_r, 1'b1);
    setCtrl(64'h8001_0001, 64'h0);
    @(negedge clk_sys);
    chkBit(protModeOn_r, 1'b0);
    chkBit(supWriteProtect_r, 1'b0);
    chkBit(ignorePageCacheBits_r, 1'b0);
    setCtrl(64'h4000_0000, 64'h0);
    @(negedge clk_sys);
    chkBit(cacheAllocEnable_r, 1'b1);
    $display("test controls done");
  endtask

  // tem holds task flag, trap-all, monitor
  task automatic iCase(input logic [2:0] tem, input logic [3:0] k, input logic [7:0] vec);
    setCtrl(64'he, {60'h0, tem, 1'b0});
    pm.issue(k);
    chkBit(instrFault_r, vec != 8'h0);
    if (vec != 8'h0)
      chk64(64'(instrFaultVec_r), 64'(vec));
  endtask

  task automatic t_instr;
    iCase(3'b101, 4'b0010, VEC_DEV_UNAVAIL);
    iCase(3'b100, 4'b0010, 8'h0);
    iCase(3'b011, 4'b0010, 8'h0);
    iCase(3'b010, 4'b1000, VEC_DEV_UNAVAIL);
    iCase(3'b010, 4'b0100, VEC_INVALID_OP);
    iCase(3'b010, 4'b0101, VEC_DEV_UNAVAIL);
    iCase(3'b100, 4'b1000, VEC_DEV_UNAVAIL);
    iCase(3'b100, 4'b0100, VEC_DEV_UNAVAIL);
    iCase(3'b001, 4'b1000, 8'h0);
    pm.flag(1'b1);
    ctrlShadow[TASK_SW_BIT] = 1'b1;
    pm.issue(4'b1000);
    chkBit(instrFault_r, 1'b1);
    pm.flag(1'b0);
    ctrlShadow[TASK_SW_BIT] = 1'b0;
    pm.issue(4'b1000);
    chkBit(instrFault_r, 1'b0);
    pm.flag(1'b1);
    ctrlShadow[TASK_SW_BIT] = 1'b1;
    setCtrl(64'h8, 64'h0);
    pm.issue(4'b1000);
    chkBit(instrFault_r, 1'b0);
    $display("test instructions done");
  endtask

  task automatic mCase(input logic un, input logic [1:0] current_priv_level, input logic exp);
    @(negedge clk_sys);
    memValid = 1'b1;
    memUnaligned = un;
    currentPrivLevel = current_priv_level;
    @(negedge clk_sys);
    memValid = 1'b0;
    memUnaligned = ~un;
    chkBit(alignFault_r, exp);
  endtask

  task automatic t_align;
    setCtrl(64'h0, 64'h4_0000);
    mv(1'b1, SEL_FLAGS, 64'h4_0000, 1'b1, 8'h0);
    mCase(1'b1, 2'h3, 1'b1);
    mCase(1'b1, 2'h2, 1'b0);
    mCase(1'b0, 2'h3, 1'b0);
    mv(1'b1, SEL_FLAGS, 64'h0, 1'b1, 8'h0);
    mCase(1'b1, 2'h3, 1'b0);
    mv(1'b1, SEL_FLAGS, 64'h4_0000, 1'b1, 8'h0);
    setCtrl(64'h4_0000, 64'h0);
    mCase(1'b1, 2'h3, 1'b0);
    $display("test alignment done");
  endtask

  // exception pulse, or acknowledge when exc is low
  task automatic fpEvent(input logic exc);
    @(negedge clk_sys);
    fpException = exc;
    fpErrorAck = ~exc;
    @(negedge clk_sys);
    fpException = 1'b0;
    fpErrorAck = 1'b0;
  endtask

  // ignore pin passes two sync flops, so wait three cycles
  task automatic t_fp;
    fpEvent(1'b1);
    chkBit(fpErrorOut_r, 1'b1);
    fpEvent(1'b0);
    chkBit(fpErrorOut_r, 1'b0);
    fpErrorIgnoreIn = 1'b1;
    repeat (3) @(negedge clk_sys);
    fpEvent(1'b1);
    chkBit(fpErrorOut_r, 1'b0);
    fpErrorIgnoreIn = 1'b0;
    setCtrl(64'h0, 64'h20);
    repeat (3) @(negedge clk_sys);
    fpEvent(1'b1);
    chkBit(fpErrorOut_r, 1'b0);
    chkBit(fpInternalReport_r, 1'b1);
    $display("test fp errors done");
  endtask

  // reset then scenarios
  initial
  begin
    reset = 1'b1;
    memValid = 1'b0;
    memUnaligned = 1'b0;
    currentPrivLevel = 2'h0;
    fpException = 1'b0;
    fpErrorAck = 1'b0;
    fpErrorIgnoreIn = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    t_regs;
    t_pfault;
    t_faults;
    t_ctrl;
    t_instr;
    t_align;
    t_fp;
    close_out;
  end

  // watchdog, well beyond the roughly 180 cycles the scenarios need
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    close_out;
  end
endmodule
